// *** logic/smr_defines.svh ***
// Offsets, field positions, reset values and timing counts for the supply monitor reset logic
`ifndef SMR_DEFINES_SVH
`define SMR_DEFINES_SVH

`define SMR_SUPPLY_MON_CTRL_ADDR 8'hFF
`define SMR_RESET_SOURCE_ADDR    8'hEF
`define SMR_POWER_UNIT_MODE_ADDR 8'hB5

`define SMR_BIT_CORE_EN          7
`define SMR_BIT_CORE_STAT        6
`define SMR_BIT_CORE_WARN_OK     5
`define SMR_BIT_BAT_WARN_OK      4
`define SMR_BIT_CORE_WARN_IE     3
`define SMR_BIT_BAT_WARN_IE      2
`define SMR_BIT_POWER_ON_FLAG    1
`define SMR_BIT_SW_RESET         4
`define SMR_BIT_FLASH_ERR_FLAG   6
`define SMR_BIT_BAT_MON_DISABLE  5

`define SMR_CORE_WARN_IE_RST     1'h1
`define SMR_BAT_WARN_IE_RST      1'h0

`define SMR_CLK_HZ               50000000
`define SMR_POR_DELAY_LOW_MS     3
`define SMR_POR_DELAY_MID_MS     7
`define SMR_POR_DELAY_HIGH_MS    15
`define SMR_MS_CYCLES            (`SMR_CLK_HZ / 1000)

`endif

// *** logic/smr_pkg.sv ***
// Types shared by the supply monitor reset logic
package smr_pkg;
   typedef enum logic [1:0] {
      SMR_ST_POWER_UP = 2'b00,
      SMR_ST_DELAY    = 2'b01,
      SMR_ST_RUN      = 2'b10,
      SMR_ST_FAIL     = 2'b11
   } smr_state_t;

   typedef enum logic [1:0] {
      SMR_BAT_LOW  = 2'b00,
      SMR_BAT_MID  = 2'b01,
      SMR_BAT_HIGH = 2'b10
   } smr_bat_range_t;
endpackage

// *** logic/smr_supply_reset.sv ***
// Supply monitor reset logic: power-on and power-fail resets, flags, warnings
// Function
// - Hold reset, reset pin released, until battery above power-on threshold.
// - Wait the power-on release delay (3, 7 or 15 ms) before release.
// - Set the power-on flag on exit from power-on reset.
// - Any reset but power-on and power-fail clears the power-on flag; other flags then undefined.
// - Every reset restarts program execution at address 0x0000.
// - Battery monitor disable: every reset but power-fail becomes full power-on, re-enabling monitor.
// - Power-on and power-fail resets enable and select the core monitor.
// - Enabled and selected monitor, core below threshold: pin low, core reset.
// - After power-fail reset the power-on flag reads one.
// - Only power-on and power-fail resets change core monitor enable and select.
// - Sleep suppresses power-fail reset; wake keeps software settings.
// - Core warning status follows the warning comparator.
// - Flash erase or write with core monitor disabled causes a flash-error reset.
// - No release delay after a core monitor reset.
// - Selecting an unsettled monitor may produce a system reset.
// - Enable bit powers the monitor; no reset unless also selected.
// - Read-only status bit shows core above reset threshold.
// - Core warning interrupt enable gates that interrupt; reset value one.
// - Battery warning status read-only; its interrupt enable resets to zero.
// - Control register bits 1 to 0 read zero, writes ignored.
`timescale 1ns/10ps
`include "smr_defines.svh"

module smr_supply_reset (
   // Clock and reset
   input  wire logic                  ref_clk_in,
   input  wire logic                  arst_n_in,
   // Analog comparators (asynchronous)
   input  wire logic                  bat_above_por_in,
   input  wire logic                  core_above_rst_in,
   input  wire logic                  core_above_warn_in,
   input  wire logic                  bat_above_warn_in,
   input  wire logic                  core_mon_settled_in,
   input  wire smr_pkg::smr_bat_range_t bat_range_in,
   // Core events
   input  wire logic                  sleep_in,
   input  wire logic                  other_reset_in,
   input  wire logic                  flash_wr_erase_in,
   // Special-function register port
   input  wire logic [7:0]            sfr_addr_in,
   input  wire logic                  sfr_wr_in,
   input  wire logic [7:0]            sfr_wdata_in,
   output logic      [7:0]            sfr_rdata_out,
   // Reset and interrupt outputs
   output logic                       core_reset_out,
   output logic [15:0]                reset_vector_out,
   output logic                       rst_pin_out,
   output logic                       rst_pin_oe_out,
   output logic                       rst_pullup_en_out,
   output logic                       core_mon_power_out,
   output logic                       bat_mon_power_out,
   output logic                       core_warn_irq_out,
   output logic                       bat_warn_irq_out
);
   localparam int unsigned LOW_CYC  = `SMR_POR_DELAY_LOW_MS * `SMR_MS_CYCLES;
   localparam int unsigned MID_CYC  = `SMR_POR_DELAY_MID_MS * `SMR_MS_CYCLES;
   localparam int unsigned HIGH_CYC = `SMR_POR_DELAY_HIGH_MS * `SMR_MS_CYCLES;

   smr_pkg::smr_state_t state_q;
   logic [4:0]  sync1_q;
   logic [4:0]  sync2_q;
   logic [19:0] delay_q;
   logic [19:0] delay_target;
   logic        core_en_q;
   logic        core_sel_q;
   logic        por_flag_q;
   logic        flash_err_q;
   logic        core_warn_ie_q;
   logic        bat_warn_ie_q;
   logic        bat_mon_dis_q;
   logic        bat_ok;
   logic        core_ok;
   logic        core_warn_ok;
   logic        bat_warn_ok;
   logic        mon_settled;
   logic        wr_ctrl;
   logic        wr_rsrc;
   logic        wr_pmu;
   logic        sw_reset;
   logic        flash_err;
   logic        any_reset;
   logic        fail_reset;

   // Two-flop synchronisers for analog comparator outputs
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {core_mon_settled_in, bat_above_warn_in, core_above_warn_in,
                     core_above_rst_in, bat_above_por_in};
         sync2_q <= sync1_q;
      end
   end

   assign bat_ok       = sync2_q[0];
   assign core_ok      = sync2_q[1];
   assign core_warn_ok = sync2_q[2];
   assign bat_warn_ok  = sync2_q[3];
   assign mon_settled  = sync2_q[4];

   assign wr_ctrl = sfr_wr_in && (sfr_addr_in == `SMR_SUPPLY_MON_CTRL_ADDR);
   assign wr_rsrc = sfr_wr_in && (sfr_addr_in == `SMR_RESET_SOURCE_ADDR);
   assign wr_pmu  = sfr_wr_in && (sfr_addr_in == `SMR_POWER_UNIT_MODE_ADDR);
   assign sw_reset = wr_rsrc && sfr_wdata_in[`SMR_BIT_SW_RESET];

   // Power-fail: enabled, selected, awake monitor sees low core or is not settled
   assign fail_reset = (state_q == smr_pkg::SMR_ST_RUN) && core_en_q && core_sel_q
                       && !sleep_in && (!core_ok || !mon_settled);
   assign flash_err  = (state_q == smr_pkg::SMR_ST_RUN) && flash_wr_erase_in
                       && !core_en_q;
   assign any_reset  = (state_q == smr_pkg::SMR_ST_RUN)
                       && (other_reset_in || sw_reset || flash_err);

   always_comb begin
      case (bat_range_in)
         smr_pkg::SMR_BAT_LOW:  delay_target = 20'(LOW_CYC - 1);
         smr_pkg::SMR_BAT_MID:  delay_target = 20'(MID_CYC - 1);
         smr_pkg::SMR_BAT_HIGH: delay_target = 20'(HIGH_CYC - 1);
         default:               delay_target = 20'(HIGH_CYC - 1);
      endcase
   end

   // Sequencer: power-up, release delay, run, power-fail
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= smr_pkg::SMR_ST_POWER_UP;
         delay_q <= 20'h00000;
      end else begin
         case (state_q)
            smr_pkg::SMR_ST_POWER_UP: begin
               delay_q <= 20'h00000;
               if (bat_ok) begin
                  state_q <= smr_pkg::SMR_ST_DELAY;
               end
            end
            smr_pkg::SMR_ST_DELAY: begin
               if (!bat_ok) begin
                  state_q <= smr_pkg::SMR_ST_POWER_UP;
               end else if (delay_q >= delay_target) begin
                  state_q <= smr_pkg::SMR_ST_RUN;
               end else begin
                  delay_q <= delay_q + 20'h00001;
               end
            end
            smr_pkg::SMR_ST_RUN: begin
               if (!bat_ok || (bat_mon_dis_q && any_reset)) begin
                  state_q <= smr_pkg::SMR_ST_POWER_UP;
               end else if (fail_reset) begin
                  state_q <= smr_pkg::SMR_ST_FAIL;
               end
            end
            smr_pkg::SMR_ST_FAIL: begin
               if (!bat_ok) begin
                  state_q <= smr_pkg::SMR_ST_POWER_UP;
               end else if (core_ok && mon_settled) begin
                  state_q <= smr_pkg::SMR_ST_RUN;
               end
            end
            default: state_q <= smr_pkg::SMR_ST_POWER_UP;
         endcase
      end
   end

   // Core monitor enable and select survive all but power-on and power-fail
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         core_en_q  <= 1'b1;
         core_sel_q <= 1'b1;
      end else if (state_q == smr_pkg::SMR_ST_POWER_UP || state_q == smr_pkg::SMR_ST_FAIL) begin
         core_en_q  <= 1'b1;
         core_sel_q <= 1'b1;
      end else if (state_q == smr_pkg::SMR_ST_RUN && !any_reset) begin
         if (wr_ctrl) begin
            core_en_q <= sfr_wdata_in[`SMR_BIT_CORE_EN];
         end
         if (wr_rsrc) begin
            core_sel_q <= sfr_wdata_in[`SMR_BIT_POWER_ON_FLAG];
         end
      end
   end

   // Power-on flag and flash-error cause flag
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         por_flag_q  <= 1'b1;
         flash_err_q <= 1'b0;
      end else if (state_q == smr_pkg::SMR_ST_POWER_UP || state_q == smr_pkg::SMR_ST_FAIL) begin
         por_flag_q  <= 1'b1;
         flash_err_q <= 1'b0;
      end else if (any_reset && !bat_mon_dis_q) begin
         por_flag_q  <= 1'b0;
         flash_err_q <= flash_err;
      end
   end

   // Interrupt enables and battery monitor disable
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         core_warn_ie_q <= `SMR_CORE_WARN_IE_RST;
         bat_warn_ie_q  <= `SMR_BAT_WARN_IE_RST;
         bat_mon_dis_q  <= 1'b0;
      end else if (state_q != smr_pkg::SMR_ST_RUN || any_reset) begin
         core_warn_ie_q <= `SMR_CORE_WARN_IE_RST;
         bat_warn_ie_q  <= `SMR_BAT_WARN_IE_RST;
         if (state_q == smr_pkg::SMR_ST_POWER_UP) begin
            bat_mon_dis_q <= 1'b0;
         end
      end else begin
         if (wr_ctrl) begin
            core_warn_ie_q <= sfr_wdata_in[`SMR_BIT_CORE_WARN_IE];
            bat_warn_ie_q  <= sfr_wdata_in[`SMR_BIT_BAT_WARN_IE];
         end
         if (wr_pmu && sfr_wdata_in[`SMR_BIT_BAT_MON_DISABLE]) begin
            bat_mon_dis_q <= 1'b1;
         end
      end
   end

   // Register read-back; low control bits read zero
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sfr_rdata_out <= 8'h00;
      end else begin
         case (sfr_addr_in)
            `SMR_SUPPLY_MON_CTRL_ADDR:
               sfr_rdata_out <= {core_en_q, core_ok, core_warn_ok, bat_warn_ok,
                                 core_warn_ie_q, bat_warn_ie_q, 2'b00};
            `SMR_RESET_SOURCE_ADDR:
               sfr_rdata_out <= {1'b0, flash_err_q, 4'h0, por_flag_q, 1'b0};
            `SMR_POWER_UNIT_MODE_ADDR:
               sfr_rdata_out <= {2'b00, bat_mon_dis_q, 5'h00};
            default:
               sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   // Outputs; the system reset is held for as long as any other reset cause is present
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         core_reset_out    <= 1'b1;
         rst_pin_oe_out    <= 1'b0;
         rst_pullup_en_out <= 1'b0;
         core_warn_irq_out <= 1'b0;
         bat_warn_irq_out  <= 1'b0;
      end else begin
         core_reset_out    <= (state_q != smr_pkg::SMR_ST_RUN) || any_reset
                              || fail_reset;
         rst_pin_oe_out    <= (state_q == smr_pkg::SMR_ST_FAIL) || fail_reset;
         rst_pullup_en_out <= (state_q == smr_pkg::SMR_ST_RUN) || (state_q == smr_pkg::SMR_ST_FAIL);
         // Held off outside run: synchronisers read low just after reset
         core_warn_irq_out <= (state_q == smr_pkg::SMR_ST_RUN) && core_warn_ie_q
                              && !core_warn_ok;
         bat_warn_irq_out  <= (state_q == smr_pkg::SMR_ST_RUN) && bat_warn_ie_q
                              && !bat_warn_ok;
      end
   end

   assign reset_vector_out   = 16'h0000;
   assign rst_pin_out        = 1'b0;
   assign core_mon_power_out = core_en_q;
   assign bat_mon_power_out  = !bat_mon_dis_q;
endmodule

// *** verif/smr_analog_model.sv ***
// Behavioural model of the core supply monitor output settling
`timescale 1ns/10ps
module smr_analog_model #(
   parameter int SETTLE = 8
) (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic arst_n_in,
   // Monitor power from the block
   input  wire logic core_mon_power_in,
   // Comparator output
   output logic      core_mon_settled_out
);
   int cnt_q;
   // Output untrusted until the turn-on time has passed
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         cnt_q <= 0;
      else if (!core_mon_power_in)
         cnt_q <= 0;
      else if (cnt_q < SETTLE)
         cnt_q <= cnt_q + 1;
   end
   assign core_mon_settled_out = (cnt_q == SETTLE);
endmodule

// *** verif/smr_supply_reset_chk.sv ***
// Assertion checker for the supply monitor reset logic
`timescale 1ns/10ps
`include "smr_defines.svh"
module smr_chk (
   input wire logic        ref_clk_in,
   input wire logic        arst_n_in,
   input wire logic        core_above_rst_in,
   input wire logic        core_above_warn_in,
   input wire logic        bat_above_warn_in,
   input wire logic        sleep_in,
   input wire logic [7:0]  sfr_addr_in,
   input wire logic [7:0]  sfr_rdata_out,
   input wire logic        core_reset_out,
   input wire logic [15:0] reset_vector_out,
   input wire logic        rst_pin_out,
   input wire logic        rst_pin_oe_out,
   input wire logic        rst_pullup_en_out,
   input wire logic        core_mon_power_out,
   input wire logic        core_warn_irq_out,
   input wire logic        bat_warn_irq_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   vector_zero_a: assert property (reset_vector_out == 16'h0000)
      else $error("reset vector not zero");
   pin_drive_a: assert property (rst_pin_oe_out |-> core_reset_out && !rst_pin_out)
      else $error("reset pin driven outside reset");
   pullup_off_a: assert property (!rst_pullup_en_out |-> core_reset_out && !rst_pin_oe_out)
      else $error("pull-up off outside power-up");
   fast_release_a: assert property ((rst_pin_oe_out && core_above_rst_in) [*4]
      |-> ##[1:4] !core_reset_out) else $error("slow release after supply reset");
   sleep_quiet_a: assert property (sleep_in [*4] |-> !$rose(rst_pin_oe_out))
      else $error("supply reset during sleep");
   disabled_quiet_a: assert property (!core_mon_power_out [*3] |-> !$rose(rst_pin_oe_out))
      else $error("disabled monitor reset the core");
   core_warn_a: assert property (core_above_warn_in [*4] |-> !core_warn_irq_out)
      else $error("core warning request with supply ok");
   bat_warn_a: assert property (bat_above_warn_in [*4] |-> !bat_warn_irq_out)
      else $error("battery warning request with supply ok");
   status_bit_a: assert property ($stable(core_above_rst_in) [*4] ##0 (!core_reset_out
      && $past(sfr_addr_in) == `SMR_SUPPLY_MON_CTRL_ADDR)
      |-> sfr_rdata_out[6] == core_above_rst_in) else $error("status bit wrong");
   fail_enable_a: assert property ($fell(rst_pin_oe_out) |-> core_mon_power_out)
      else $error("monitor off after supply reset");
   cover property ($rose(rst_pin_oe_out));
   cover property ($fell(core_reset_out));
   cover property (core_warn_irq_out && bat_warn_irq_out);
endmodule
bind smr_supply_reset smr_chk i_smr_chk (.ref_clk_in, .arst_n_in, .core_above_rst_in,
   .core_above_warn_in, .bat_above_warn_in, .sleep_in, .sfr_addr_in, .sfr_rdata_out,
   .core_reset_out, .reset_vector_out, .rst_pin_out, .rst_pin_oe_out, .rst_pullup_en_out,
   .core_mon_power_out, .core_warn_irq_out, .bat_warn_irq_out);

// *** verif/smr_supply_reset_tb.sv ***
// Directed testbench for the supply monitor reset logic
`timescale 1ns/10ps
`include "smr_defines.svh"
module smr_supply_reset_tb;
   localparam logic [7:0] ctl = `SMR_SUPPLY_MON_CTRL_ADDR;
   localparam logic [7:0] src = `SMR_RESET_SOURCE_ADDR;
   localparam logic [7:0] pmu = `SMR_POWER_UNIT_MODE_ADDR;
   localparam int         dly = `SMR_POR_DELAY_LOW_MS * `SMR_MS_CYCLES;
   logic        ref_clk_in, arst_n_in, bat_above_por_in, core_above_rst_in;
   logic        core_above_warn_in, bat_above_warn_in, core_mon_settled_in, sleep_in;
   logic        other_reset_in, flash_wr_erase_in, sfr_wr_in, core_reset_out, rst_pin_out;
   logic        rst_pin_oe_out, rst_pullup_en_out, core_mon_power_out, bat_mon_power_out;
   logic        core_warn_irq_out, bat_warn_irq_out;
   logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
   logic [15:0] reset_vector_out;
   int          fails = 0, n_tests = 0, cyc = 0, t;
   smr_supply_reset i_smr_supply_reset (.ref_clk_in, .arst_n_in, .bat_above_por_in,
      .core_above_rst_in, .core_above_warn_in, .bat_above_warn_in, .core_mon_settled_in,
      .bat_range_in(smr_pkg::SMR_BAT_LOW), .sleep_in, .other_reset_in, .flash_wr_erase_in,
      .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .core_reset_out,
      .reset_vector_out, .rst_pin_out, .rst_pin_oe_out, .rst_pullup_en_out,
      .core_mon_power_out, .bat_mon_power_out, .core_warn_irq_out, .bat_warn_irq_out);
   smr_analog_model i_smr_analog_model (.ref_clk_in, .arst_n_in,
      .core_mon_power_in(core_mon_power_out), .core_mon_settled_out(core_mon_settled_in));
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge ref_clk_in) sfr_addr_in <= a;
      @(posedge ref_clk_in) #1 chk(sfr_rdata_out & m, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in) begin
         sfr_addr_in <= a;
         sfr_wdata_in <= d;
         sfr_wr_in <= 1'b1;
      end
      @(posedge ref_clk_in) sfr_wr_in <= 1'b0;
   endtask
   // Pulse one event input, then let the short reset run out
   task automatic ev(input bit fl);
      @(posedge ref_clk_in) if (fl) flash_wr_erase_in <= 1'b1; else other_reset_in <= 1'b1;
      @(posedge ref_clk_in) begin
         flash_wr_erase_in <= 1'b0;
         other_reset_in <= 1'b0;
      end
      repeat (10) @(posedge ref_clk_in);
   endtask
   // Count cycles until the core leaves reset, bounded
   task automatic wait_run(input int lim);
      t = 0;
      while (core_reset_out !== 1'b0 && t < lim) begin
         @(posedge ref_clk_in);
         #1 t++;
      end
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == dly + 20000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      {arst_n_in, bat_above_por_in, sleep_in, other_reset_in, flash_wr_erase_in} = 5'h00;
      {core_above_rst_in, core_above_warn_in, bat_above_warn_in, sfr_wr_in} = 4'hE;
      sfr_addr_in = 8'h00;
      sfr_wdata_in = 8'h00;
      repeat (10) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      repeat (20) @(posedge ref_clk_in) #1;
      chk({5'h00, core_reset_out, rst_pin_oe_out, rst_pullup_en_out}, 8'h04);
      @(posedge ref_clk_in) bat_above_por_in <= 1'b1;
      wait_run(dly + 100);
      chk(8'(t >= dly && t <= dly + 10), 8'h01);
      chk({7'h00, rst_pullup_en_out}, 8'h01);
      rd(ctl, 8'hFF, 8'hF8);
      rd(src, 8'h02, 8'h02);
      wr(src, 8'h00);
      wr(ctl, 8'h0F);
      rd(ctl, 8'hFF, 8'h7C);
      @(posedge ref_clk_in) {core_above_warn_in, bat_above_warn_in} <= 2'b00;
      repeat (5) @(posedge ref_clk_in);
      rd(ctl, 8'h30, 8'h00);
      chk({6'h00, core_warn_irq_out, bat_warn_irq_out}, 8'h03);
      wr(ctl, 8'h00);
      repeat (3) @(posedge ref_clk_in) #1;
      chk({6'h00, core_warn_irq_out, bat_warn_irq_out}, 8'h00);
      {core_above_warn_in, bat_above_warn_in} <= 2'b11;
      ev(1'b0);
      rd(ctl, 8'h80, 8'h00);
      rd(src, 8'h02, 8'h00);
      wr(src, 8'h10);
      repeat (10) @(posedge ref_clk_in);
      rd(src, 8'h12, 8'h00);
      ev(1'b1);
      rd(src, 8'h40, 8'h40);
      chk(reset_vector_out[7:0] | reset_vector_out[15:8], 8'h00);
      wr(ctl, 8'h88);
      repeat (12) @(posedge ref_clk_in);
      wr(src, 8'h02);
      @(posedge ref_clk_in) sleep_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in) core_above_rst_in <= 1'b0;
      repeat (20) @(posedge ref_clk_in) #1;
      chk({7'h00, core_reset_out}, 8'h00);
      core_above_rst_in <= 1'b1;
      // Wake only once the supply is seen good again
      repeat (5) @(posedge ref_clk_in);
      sleep_in <= 1'b0;
      rd(ctl, 8'h80, 8'h80);
      @(posedge ref_clk_in) core_above_rst_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in) #1;
      chk({6'h00, core_reset_out, rst_pin_oe_out}, 8'h03);
      @(posedge ref_clk_in) core_above_rst_in <= 1'b1;
      wait_run(100);
      chk(8'(t <= 10), 8'h01);
      rd(src, 8'h02, 8'h02);
      rd(ctl, 8'h80, 8'h80);
      wr(pmu, 8'h20);
      @(posedge ref_clk_in) #1 chk({7'h00, bat_mon_power_out}, 8'h00);
      ev(1'b0);
      #1 chk({5'h00, core_reset_out, bat_mon_power_out, rst_pullup_en_out}, 8'h06);
      close_out;
   end
endmodule
